// ===== src/art_regs.svh
// Constants of the array reference trap logic: register offsets, header
// field positions, reset values, tag and element codes, trap vectors.
// Assumes it is included by bare name after the package art_pkg.
//
// Operation
// - Element access address gets one added.
// - Long prefix traps unless inhibit bit set.
// - Store to boolean array always traps.
// - Character store needs character tag, size fit.
// - Fixnum store needs fixnum tagged data.
// - Packed, character or boolean arrays trap.
// - Packed trap vectors per load and store.
// - Args: status word, then address or data.
// - Arg two is shifted index plus one.
// - Byte-pack 0 gives 32, 1 gives 16.
// - Sizes 8,4,2,1; position from low bits.
// - Rotate loaded from the access on array traps, else full size, zero.
// - Header fields; short prefix clears inhibit, offset.
// - Length from header low bits or prefix.
// - Header fetch follows invisible pointers, latches address.
// - Header fetch into header also loads length.
`ifndef ART_REGS_SVH
`define ART_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one word each).
// ----------------------------------------------------------------------
`define ART_OFS_HEADER   8'h00
`define ART_OFS_LENGTH   8'h04
`define ART_OFS_LATCH    8'h08
`define ART_OFS_ARG0     8'h0C
`define ART_OFS_ARG1     8'h10
`define ART_OFS_ARG2     8'h14
`define ART_OFS_ROTATE   8'h18
`define ART_OFS_IRQSTAT  8'h1C
`define ART_OFS_IRQMASK  8'h20

// ----------------------------------------------------------------------
// Header field positions and masks.
// ----------------------------------------------------------------------
`define ART_ETYPE_HI     31
`define ART_ETYPE_LO     30
`define ART_BPACK_HI     29
`define ART_BPACK_LO     27
`define ART_LPRE_BIT     23
`define ART_LPI_BIT      12
`define ART_BOFS_HI      11
`define ART_BOFS_LO      7
`define ART_HDR_MASK     32'hF880_1F80
`define ART_HDR_LPMASK   32'h0000_1F80
`define ART_SLEN_MASK    32'h0000_7FFF
`define ART_ROT_POS_LO   0
`define ART_ROT_SIZE_LO  8

// ----------------------------------------------------------------------
// Element type codes, data tags, sizes and trap vectors.
// ----------------------------------------------------------------------
`define ART_ET_FIXNUM    2'h0
`define ART_ET_CHAR      2'h1
`define ART_ET_BOOLEAN   2'h2
`define ART_ET_OBJECT    2'h3
`define ART_TAG_FIXNUM   6'h08
`define ART_TAG_CHAR     6'h1A
`define ART_FULL_SIZE    6'h20
`define ART_MAX_BPACK    3'h5
`define ART_VEC_LDPACK   32'h0000_0800
`define ART_VEC_STPACK   32'h0000_0802
`define ART_VEC_MISC     32'h0000_0810

// ----------------------------------------------------------------------
// Reset values and interrupt bits.
// ----------------------------------------------------------------------
`define ART_RST_WORD     32'h0000_0000
`define ART_IRQ_TRAP     0
`define ART_IRQ_FETCH    1

`endif

// ===== src/art_pkg.sv
// Types shared by the array reference trap logic.
// Assumes no other package; constants live in art_regs.svh.
package art_pkg;

  // ----------------------------------------------------------------------
  // Trap kinds, listed from highest to lowest priority.
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ART_TRAP_NONE,
    ART_TRAP_ELEMENT,
    ART_TRAP_LONGPRE,
    ART_TRAP_RANGE,
    ART_TRAP_PACKED
  } art_trap_type;

  // ----------------------------------------------------------------------
  // Header fetch sequencer states.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ART_IDLE,
    ART_FETCH,
    ART_LENGTH
  } art_state_type;

endpackage

// ===== src/art_elem_check.sv
// Combinational trap check and byte rotate computation for one array
// element access. Assumes header and length come from registers on the
// same clock and that the caller registers every result.
`timescale 1ns/1ps
`include "art_regs.svh"

module art_elem_check (
  // Cached array state.
  input  wire logic [31:0]          header,
  input  wire logic [31:0]          length,
  // Access operands.
  input  wire logic [31:0]          index,
  input  wire logic                 isStore,
  input  wire logic [5:0]           dataTag,
  input  wire logic [31:0]          dataWord,
  // Results.
  output art_pkg::art_trap_type     trapKind,
  output logic [31:0]               adjIndex,
  output logic [5:0]                rotSize,
  output logic [4:0]                rotPos
);
  import art_pkg::*;

  // ----------------------------------------
  // Header field decode.
  // ----------------------------------------
  wire logic [1:0]  elemType = header[`ART_ETYPE_HI:`ART_ETYPE_LO];
  wire logic [2:0]  bytePack = header[`ART_BPACK_HI:`ART_BPACK_LO];
  wire logic        longPre  = header[`ART_LPRE_BIT];
  wire logic        inhibit  = header[`ART_LPI_BIT];
  // Byte offset is forced to zero for short prefix arrays.
  wire logic [4:0]  byteOfs  = longPre ?
                               header[`ART_BOFS_HI:`ART_BOFS_LO] : 5'h00;
  // Undefined pack codes are clamped so the size, mask and position shifts stay in range; the index shift takes the raw code.
  wire logic [2:0]  packEff  = (bytePack > `ART_MAX_BPACK) ?
                               `ART_MAX_BPACK : bytePack;

  // ----------------------------------------
  // Adjusted index and byte position.
  // ----------------------------------------
  wire logic [31:0] sum      = index + {27'h0000000, byteOfs};
  wire logic [31:0] lowMask  = (32'h0000_0001 << packEff) - 32'h0000_0001;
  wire logic [31:0] lowBits  = sum & lowMask;
  wire logic [2:0]  posShift = `ART_MAX_BPACK - packEff;
  wire logic [31:0] keepMask = (rotSize == `ART_FULL_SIZE) ? 32'hFFFF_FFFF
                               : ((32'h0000_0001 << rotSize) - 32'h0000_0001);
  wire logic        aboveSet = |(dataWord & ~keepMask);

  assign adjIndex = (sum >> bytePack) + 32'h0000_0001;
  assign rotSize  = `ART_FULL_SIZE >> packEff;
  // Size is a power of two, so size times low bits is a shift.
  assign rotPos   = lowBits[4:0] << posShift;

  // ----------------------------------------
  // Trap conditions.
  // ----------------------------------------
  wire logic charBad = (dataTag != `ART_TAG_CHAR) || aboveSet;
  wire logic fixBad  = (dataTag != `ART_TAG_FIXNUM);
  wire logic elemT   = isStore &&
                       ((elemType == `ART_ET_BOOLEAN) ||
                        ((elemType == `ART_ET_CHAR) && charBad) ||
                        ((elemType == `ART_ET_FIXNUM) && fixBad));
  wire logic lpreT   = longPre && !inhibit;
  wire logic rangeT  = (index >= length);
  // Packed data, or elements unlike their storage words.
  wire logic packT   = (bytePack != 3'h0) ||
                       (elemType == `ART_ET_CHAR) ||
                       (elemType == `ART_ET_BOOLEAN);

  // Element before long prefix before range before packed.
  always_comb
  begin
    if (elemT)
      trapKind = ART_TRAP_ELEMENT;
    else if (lpreT)
      trapKind = ART_TRAP_LONGPRE;
    else if (rangeT)
      trapKind = ART_TRAP_RANGE;
    else if (packT)
      trapKind = ART_TRAP_PACKED;
    else
      trapKind = ART_TRAP_NONE;
  end

endmodule

// ===== src/art_ref_trap.sv
// Array reference trap logic: cached header and length registers, the
// header fetch sequencer, element access checks and trap argument fill,
// with an AHB-Lite register slave and one level interrupt.
// Assumes the execute pipeline and memory port run on sys_clk.
`timescale 1ns/1ps
`include "art_regs.svh"

module art_ref_trap (
  // Clock and reset.
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  // AHB-Lite slave.
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  // Array element access from the pipeline.
  input  wire logic                 opValid,
  input  wire logic                 opStore,
  input  wire logic                 opUseLatch,
  input  wire logic [31:0]          opIndex,
  input  wire logic [31:0]          first_source_operand,
  input  wire logic [31:0]          second_source_operand,
  input  wire logic [5:0]           secondSourceTag,
  input  wire logic [31:0]          trap_status_word,
  input  wire logic                 otherTrap,
  // Access results.
  output logic                      opDone,
  output logic [31:0]               effAddr,
  output logic                      trapValid,
  output art_pkg::art_trap_type     trapKind,
  output logic [31:0]               trapVector,
  output logic [31:0]               trap_argument_zero,
  output logic [31:0]               trap_argument_one,
  output logic [31:0]               trap_argument_two,
  output logic [5:0]                rotSize,
  output logic [4:0]                rotPos,
  // Header fetch request and memory port.
  input  wire logic                 fetchStart,
  input  wire logic [31:0]          fetchAddr,
  input  wire logic                 fetchToHeader,
  output logic                      fetchDone,
  output logic                      memReadReq,
  output logic [31:0]               memReadAddr,
  input  wire logic                 memReadValid,
  input  wire logic                 memReadForward,
  input  wire logic [31:0]          memReadData,
  output logic [31:0]               memory_address_latch,
  // Interrupt.
  output logic                      irq
);
  import art_pkg::*;

  // ----------------------------------------
  // Storage.
  // ----------------------------------------
  logic [31:0]   header;      // Cached array header fields.
  logic [31:0]   length;      // Index limit of the array.
  logic [1:0]    irqStatus;   // Sticky event bits.
  logic [1:0]    irqMask;     // Enables for the event bits.
  logic          toHeader;    // Current fetch targets the header.
  art_state_type state;       // Header fetch sequencer.
  logic          wrPending;   // A bus write is in its data phase.
  logic [7:0]    wrAddr;      // Offset of that write.

  // ----------------------------------------
  // Element check.
  // ----------------------------------------
  art_trap_type  chkKind;
  logic [31:0]   chkAdj;
  logic [5:0]    chkSize;
  logic [4:0]    chkPos;

  art_elem_check u_check (
    .header   (header),
    .length   (length),
    .index    (opIndex),
    .isStore  (opStore),
    .dataTag  (secondSourceTag),
    .dataWord (second_source_operand),
    .trapKind (chkKind),
    .adjIndex (chkAdj),
    .rotSize  (chkSize),
    .rotPos   (chkPos)
  );

  // A trap already raised elsewhere outranks the array traps.
  wire logic       arrayTrap = (chkKind != ART_TRAP_NONE) && !otherTrap;
  // The element base is either the first source or the latched header address.
  wire logic [31:0] baseAddr = opUseLatch ? memory_address_latch
                                          : first_source_operand;
  wire logic [31:0] next_effAddr = baseAddr + opIndex
                                   + 32'h0000_0001;
  // Packed traps go to a slot per instruction, others to the misc one.
  wire logic [31:0] next_vector =
      (chkKind != ART_TRAP_PACKED) ? `ART_VEC_MISC :
      (opStore ? `ART_VEC_STPACK : `ART_VEC_LDPACK);
  // Load reports the array address, store the data to store.
  wire logic [31:0] next_arg1 = opStore ? second_source_operand
                                        : first_source_operand;

  // ----------------------------------------
  // Access result registers.
  // ----------------------------------------
  // Results hold until the next access; pulses last one cycle.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      opDone             <= 1'b0;
      effAddr            <= `ART_RST_WORD;
      trapValid          <= 1'b0;
      trapKind           <= ART_TRAP_NONE;
      trapVector         <= `ART_RST_WORD;
      trap_argument_zero <= `ART_RST_WORD;
      trap_argument_one  <= `ART_RST_WORD;
      trap_argument_two  <= `ART_RST_WORD;
      rotSize            <= `ART_FULL_SIZE;
      rotPos             <= 5'h00;
    end
    else
    begin
      opDone    <= opValid;
      trapValid <= opValid && arrayTrap;
      if (opValid)
      begin
        effAddr  <= next_effAddr;
        trapKind <= arrayTrap ? chkKind : ART_TRAP_NONE;
        if (arrayTrap)
        begin
          trapVector         <= next_vector;
          trap_argument_zero <= trap_status_word;
          trap_argument_one  <= next_arg1;
          trap_argument_two  <= chkAdj;
          rotSize            <= chkSize;
          rotPos             <= chkPos;
        end
        else
        begin
          // Saves state for the subversion: plain size, bottom zero.
          rotSize <= `ART_FULL_SIZE;
          rotPos  <= 5'h00;
        end
      end
    end
  end

  // ----------------------------------------
  // Header fetch sequencer.
  // ----------------------------------------
  wire logic hdrWord   = (state == ART_FETCH) && memReadValid
                         && !memReadForward;
  wire logic hdrLong   = memReadData[`ART_LPRE_BIT];
  // Short prefix headers keep neither inhibit nor offset.
  wire logic [31:0] next_header = memReadData & (hdrLong ? `ART_HDR_MASK
      : (`ART_HDR_MASK & ~`ART_HDR_LPMASK));
  wire logic loadHeader = hdrWord && toHeader;
  wire logic loadShort  = loadHeader && !hdrLong;
  wire logic loadLong   = (state == ART_LENGTH) && memReadValid;
  wire logic next_fetchDone = (hdrWord && !(toHeader && hdrLong))
                              || loadLong;

  // The read address follows each forward; the latch takes it only when the real header arrives.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state                <= ART_IDLE;
      memReadReq           <= 1'b0;
      memReadAddr          <= `ART_RST_WORD;
      memory_address_latch <= `ART_RST_WORD;
      toHeader             <= 1'b0;
      fetchDone            <= 1'b0;
    end
    else
    begin
      memReadReq <= 1'b0;
      fetchDone  <= next_fetchDone;
      case (state)
        ART_IDLE:
        begin
          if (fetchStart)
          begin
            memReadReq  <= 1'b1;
            memReadAddr <= fetchAddr;
            toHeader    <= fetchToHeader;
            state       <= ART_FETCH;
          end
        end
        ART_FETCH:
        begin
          if (memReadValid && memReadForward)
          begin
            // Invisible pointer: read again where it points.
            memReadReq  <= 1'b1;
            memReadAddr <= memReadData;
          end
          else if (memReadValid)
          begin
            memory_address_latch <= memReadAddr;
            if (toHeader && hdrLong)
            begin
              // Long prefix: length is the next prefix word.
              memReadReq  <= 1'b1;
              memReadAddr <= memReadAddr + 32'h0000_0001;
              state       <= ART_LENGTH;
            end
            else
              state <= ART_IDLE;
          end
        end
        ART_LENGTH:
        begin
          if (memReadValid)
            state <= ART_IDLE;
        end
        default:
          state <= ART_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // AHB-Lite decode.
  // ----------------------------------------
  wire logic       busTake = hsel && htrans[1] && hready;
  wire logic       busRead = busTake && !hwrite;
  wire logic       busWrite = busTake && hwrite;
  wire logic [7:0] rdOfs   = haddr[7:0];
  wire logic       wrHeader = wrPending && (wrAddr == `ART_OFS_HEADER);
  wire logic       wrLength = wrPending && (wrAddr == `ART_OFS_LENGTH);
  wire logic       wrStat   = wrPending && (wrAddr == `ART_OFS_IRQSTAT);
  wire logic       wrMask   = wrPending && (wrAddr == `ART_OFS_IRQMASK);
  wire logic [31:0] rotWord = {18'h00000, rotSize, 3'h0, rotPos};
  wire logic [31:0] next_rdata =
      (rdOfs == `ART_OFS_HEADER)  ? header :
      (rdOfs == `ART_OFS_LENGTH)  ? length :
      (rdOfs == `ART_OFS_LATCH)   ? memory_address_latch :
      (rdOfs == `ART_OFS_ARG0)    ? trap_argument_zero :
      (rdOfs == `ART_OFS_ARG1)    ? trap_argument_one :
      (rdOfs == `ART_OFS_ARG2)    ? trap_argument_two :
      (rdOfs == `ART_OFS_ROTATE)  ? rotWord :
      (rdOfs == `ART_OFS_IRQSTAT) ? {30'h00000000, irqStatus} :
      (rdOfs == `ART_OFS_IRQMASK) ? {30'h00000000, irqMask} :
      `ART_RST_WORD;

  // Read data is captured at the address phase so every answer is zero
  // wait; a read right behind a write to the same word sees the old value.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= `ART_RST_WORD;
      wrPending <= 1'b0;
      wrAddr    <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPending <= busWrite;
      if (busWrite)
        wrAddr <= haddr[7:0];
      if (busRead)
        hrdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Header and length registers.
  // ----------------------------------------
  // A fetch outranks a software descriptor load in the same cycle.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      header <= `ART_RST_WORD;
      length <= `ART_RST_WORD;
    end
    else
    begin
      if (loadHeader)
        header <= next_header;
      else if (wrHeader)
        header <= hwdata & (hwdata[`ART_LPRE_BIT] ? `ART_HDR_MASK
                  : (`ART_HDR_MASK & ~`ART_HDR_LPMASK));
      if (loadShort)
        length <= memReadData & `ART_SLEN_MASK;
      else if (loadLong)
        length <= memReadData;
      else if (wrLength)
        length <= hwdata;
    end
  end

  // ----------------------------------------
  // Interrupt status, mask and output.
  // ----------------------------------------
  wire logic [1:0] irqEvent = {next_fetchDone, opValid && arrayTrap};
  wire logic [1:0] irqClear = wrStat ? hwdata[1:0] : 2'h0;
  // A new event wins over a clear in the same cycle.
  wire logic [1:0] next_irqStatus = (irqStatus & ~irqClear) | irqEvent;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      irqStatus <= 2'h0;
      irqMask   <= 2'h0;
      irq       <= 1'b0;
    end
    else
    begin
      irqStatus <= next_irqStatus;
      if (wrMask)
        irqMask <= hwdata[1:0];
      irq <= |(irqStatus & irqMask);
    end
  end

endmodule

// ===== verif/art_ref_trap_checker.sv
// -----------------------------------------------------------------
// Checker for the array reference trap logic, bound to its top.
// -----------------------------------------------------------------
// Assumes one clock, sys_clk, and the active high reset.
`timescale 1ns/1ps
`include "art_regs.svh"
module art_ref_trap_checker (
  // Clock and reset.
  input wire logic         sys_clk,
  input wire logic         reset,
  // Element access.
  input wire logic         opValid,
  input wire logic         opStore,
  input wire logic         opUseLatch,
  input wire logic [31:0]  opIndex,
  input wire logic [31:0]  first_source_operand,
  input wire logic [31:0]  second_source_operand,
  input wire logic [31:0]  trap_status_word,
  input wire logic         otherTrap,
  input wire logic         opDone,
  input wire logic [31:0]  effAddr,
  input wire logic         trapValid,
  input art_pkg::art_trap_type trapKind,
  input wire logic [31:0]  trapVector,
  input wire logic [31:0]  trap_argument_zero,
  input wire logic [31:0]  trap_argument_one,
  input wire logic [5:0]   rotSize,
  input wire logic [4:0]   rotPos,
  // Memory port.
  input wire logic         memReadReq,
  input wire logic [31:0]  memReadAddr,
  input wire logic         memReadValid,
  input wire logic         memReadForward,
  input wire logic [31:0]  memReadData
);
  import art_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_done_follows: assert property (opDone == $past(opValid))
    else $error("done pulse late");
  a_eff_address: assert property (opValid && !opUseLatch |=>
    effAddr == $past(first_source_operand) + $past(opIndex) + 32'h1)
    else $error("bad address");
  a_other_quiet: assert property (opValid && otherTrap |=>
    !trapValid && rotSize == 6'h20 && rotPos == 5'h00)
    else $error("rotate not full");
  a_trap_done: assert property (trapValid |-> opDone)
    else $error("trap not done");
  a_arg_zero: assert property (trapValid |->
    trap_argument_zero == $past(trap_status_word))
    else $error("bad argument zero");
  a_arg_store: assert property (trapValid && $past(opStore) |->
    trap_argument_one == $past(second_source_operand))
    else $error("bad argument one");
  a_packed_vec: assert property (trapValid &&
    trapKind == ART_TRAP_PACKED |-> trapVector == ($past(opStore) ?
    `ART_VEC_STPACK : `ART_VEC_LDPACK))
    else $error("bad vector");
  a_rot_size: assert property (opDone |->
    $onehot(rotSize) && rotSize <= 6'h20)
    else $error("bad rotate size");
  a_fwd_follow: assert property (memReadValid && memReadForward |=>
    memReadReq && memReadAddr == $past(memReadData))
    else $error("pointer not followed");
endmodule
bind art_ref_trap art_ref_trap_checker i_art_ref_trap_checker (.*);

// ===== verif/art_mem_model.sv
// Memory model answering header fetch reads after 1 to 4 cycles.
// Assumes one outstanding read and the address held until answered.
`timescale 1ns/1ps
module art_mem_model (
  // Clock and reset.
  input wire logic         sys_clk,
  input wire logic         reset,
  // Read port.
  input wire logic         memReadReq,
  input wire logic [31:0]  memReadAddr,
  output logic             memReadValid,
  output logic             memReadForward,
  output logic [31:0]      memReadData
);
  logic [1:0] cnt;  // Cycles left before the answer.
  logic       busy; // A read is outstanding.
  // Data toggles outside answers so a stale word is never mistaken.
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      {memReadValid, memReadForward, busy, cnt} <= '0;
      memReadData <= 32'h0;
    end
    else
    begin
      memReadValid <= 1'b0;
      memReadForward <= 1'b0;
      memReadData <= ~memReadData;
      if (memReadReq)
      begin
        busy <= 1'b1;
        cnt <= memReadAddr[1:0];
      end
      else if (busy && cnt == 2'h0)
      begin
        busy <= 1'b0;
        memReadValid <= 1'b1;
        memReadForward <= (memReadAddr == 32'h100);
        case (memReadAddr)
          32'h100: memReadData <= 32'h200;
          32'h200: memReadData <= 32'hC;
          32'h300: memReadData <= 32'h1080_1200;
          32'h301: memReadData <= 32'h40;
          default: memReadData <= 32'h0;
        endcase
      end
      else if (busy) cnt <= cnt - 2'h1;
    end
endmodule

// ===== verif/art_ref_trap_bench.sv
// Self-checking bench: bus, element access and header fetch calls.
// Assumes the far-side memory model.
`timescale 1ns/1ps
`include "art_regs.svh"
module art_ref_trap_bench;
  import art_pkg::*;
  logic sys_clk, reset, hsel, hwrite, hresp, hreadyout, opValid, opStore;
  logic opUseLatch, otherTrap, opDone, trapValid, fetchStart, irq;
  logic fetchToHeader, fetchDone, memReadReq, memReadValid, memReadForward;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] secondSourceTag, rotSize;
  logic [4:0] rotPos;
  art_trap_type trapKind;
  wire logic hready;
  logic [31:0] haddr, hwdata, hrdata, opIndex, first_source_operand, r;
  logic [31:0] second_source_operand, trap_status_word, effAddr, trapVector;
  logic [31:0] trap_argument_zero, trap_argument_one, trap_argument_two;
  logic [31:0] fetchAddr, memReadAddr, memReadData, memory_address_latch;
  int errors, cmp_count;
  assign hready = hreadyout;
  art_ref_trap i_art_ref_trap (.*);
  art_mem_model i_art_mem_model (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task report_and_stop;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One bus transfer; read data is taken at the data phase edge.
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    {hsel, haddr, hwrite, htrans, hsize} <= {1'b1, a, w, 2'h2, 3'h2};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(r, e);
    chk(hresp, 0);
  endtask
  // One element access, then its results checked, trap vector and arguments only on a trap.
  task acc(input logic st, input logic [31:0] idx, input logic [5:0] tg,
    input logic [2:0] k, input logic [31:0] v, input logic [31:0] a2,
    input logic [5:0] sz, input logic [4:0] ps);
    {opValid, opStore, opIndex, secondSourceTag} <= {1'b1, st, idx, tg};
    @(posedge sys_clk);
    opValid <= 1'b0;
    #1;
    chk(opDone, 1);
    chk(effAddr, (opUseLatch ? 32'h200 : 32'h1000) + idx + 32'h1);
    chk(trapKind, k);
    chk(trapValid, k != 3'h0);
    chk({rotSize, rotPos}, {sz, ps});
    if (k != 3'h0)
    begin
      chk(trapVector, v);
      chk(trap_argument_zero, 32'hC0DE);
      chk(trap_argument_one, st ? second_source_operand : 32'h1000);
      chk(trap_argument_two, a2);
    end
    @(posedge sys_clk);
  endtask
  task fetch(input logic [31:0] a);
    int n;
    {fetchStart, fetchAddr, fetchToHeader} <= {1'b1, a, 1'b1};
    @(posedge sys_clk);
    fetchStart <= 1'b0;
    n = 0;
    while (fetchDone !== 1'b1 && n < 40)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(n < 40, 1);
  endtask
  initial
  begin
    repeat (4000) @(posedge sys_clk);
    errors++;
    report_and_stop;
  end
  initial
  begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} <= '0;
    {opValid, opStore, opUseLatch, otherTrap, opIndex} <= '0;
    {fetchStart, fetchToHeader, fetchAddr, secondSourceTag} <= '0;
    first_source_operand <= 32'h1000;
    second_source_operand <= 32'h55;
    trap_status_word <= 32'hC0DE;
    reset <= 1'b1;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(0, 0);
    rd(32'h18, 32'h2000);
    rd(32'h24, 0);
    ahb(1, 4, 32'hA);
    ahb(1, 0, 0);
    acc(0, 3, 8, ART_TRAP_NONE, 0, 0, 32, 0);
    acc(0, 9, 8, ART_TRAP_NONE, 0, 0, 32, 0);
    acc(0, 10, 8, ART_TRAP_RANGE, `ART_VEC_MISC, 11, 32, 0);
    acc(1, 3, 6'h1A, ART_TRAP_ELEMENT, `ART_VEC_MISC, 4, 32, 0);
    otherTrap <= 1'b1;
    acc(1, 3, 6'h1A, ART_TRAP_NONE, 0, 0, 32, 0);
    otherTrap <= 1'b0;
    for (int bp = 1; bp < 6; bp++)
    begin
      ahb(1, 0, 32'(bp) << 27);
      acc(0, 1, 8, ART_TRAP_PACKED, `ART_VEC_LDPACK, 1, 6'(32 >> bp),
        5'(32 >> bp));
    end
    $display("test access done");
    ahb(1, 0, 32'h1000_0000);
    acc(1, 7, 8, ART_TRAP_PACKED, `ART_VEC_STPACK, 2, 8, 24);
    ahb(1, 0, 32'hA800_0000);
    acc(1, 1, 8, ART_TRAP_ELEMENT, `ART_VEC_MISC, 1, 1, 1);
    acc(0, 1, 8, ART_TRAP_PACKED, `ART_VEC_LDPACK, 1, 1, 1);
    ahb(1, 0, 32'h4800_0000);
    acc(1, 0, 6'h1A, ART_TRAP_PACKED, `ART_VEC_STPACK, 1, 16, 0);
    second_source_operand <= 32'h0010_0000;
    acc(1, 0, 6'h1A, ART_TRAP_ELEMENT, `ART_VEC_MISC, 1, 16, 0);
    ahb(1, 0, 32'h0080_0000);
    acc(0, 1, 8, ART_TRAP_LONGPRE, `ART_VEC_MISC, 2, 32, 0);
    ahb(1, 0, 32'h1080_1200);
    rd(0, 32'h1080_1200);
    acc(0, 5, 8, ART_TRAP_PACKED, `ART_VEC_LDPACK, 3, 8, 8);
    ahb(1, 0, 32'h0000_1F80);
    rd(0, 0);
    $display("test traps done");
    ahb(1, 32'h20, 2);
    fetch(32'h100);
    opUseLatch <= 1'b1;
    acc(0, 2, 8, ART_TRAP_NONE, 0, 0, 32, 0);
    opUseLatch <= 1'b0;
    chk(memory_address_latch, 32'h200);
    rd(4, 32'hC);
    rd(32'h1C, 3);
    chk(irq, 1);
    ahb(1, 32'h1C, 2);
    repeat (2) @(posedge sys_clk);
    chk(irq, 0);
    fetch(32'h300);
    rd(4, 32'h40);
    rd(0, 32'h1080_1200);
    $display("test fetch done");
    report_and_stop;
  end
endmodule
